//--- fcsf_map.svh
// fcsf_map.svh: register offsets, bit positions and reset values of the flash status flags
// assumes: included by bare name from the package and the design file
`ifndef FCSF_MAP_SVH
`define FCSF_MAP_SVH
`define FCSF_ADDR_W 8
`define FCSF_OFS_STAT 8'h00
`define FCSF_OFS_IRQ_STS 8'h04
`define FCSF_OFS_IRQ_MSK 8'h08
`define FCSF_BIT_CMD_CMPL 7
`define FCSF_BIT_ACC_ERR 5
`define FCSF_BIT_PROT_VIOL 4
`define FCSF_BIT_BUSY 3
`define FCSF_BIT_RSVD 2
`define FCSF_BIT_CSTAT_LO 0
`define FCSF_CSTAT_W 2
`define FCSF_IRQ_W 4
`define FCSF_IRQ_CMD 0
`define FCSF_IRQ_ACC 1
`define FCSF_IRQ_PROT 2
`define FCSF_IRQ_MGS 3
`define FCSF_STAT_RST 8'h80
`define FCSF_CMD_CMPL_RST 1'b1
`define FCSF_IRQ_MSK_RST 4'h0
`define FCSF_RESP_OKAY 2'h0
`define FCSF_RESP_DECERR 2'h3
`endif

//--- fcsf_pkg.sv
// fcsf_pkg.sv: types of the flash status flag block
// assumes: fcsf_map.svh on the include path
`include "fcsf_map.svh"
package fcsf_pkg;
    typedef logic [`FCSF_ADDR_W-1:0] fcsf_addr_t;
    typedef enum logic [0:0] {
        FCSF_WR_IDLE = 1'b0,
        FCSF_WR_RESP = 1'b1
    } fcsf_wr_e;
    typedef struct packed {
        logic awready;
        logic wready;
        fcsf_addr_t awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        fcsf_wr_e wst;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rd_stat;
        logic cmd_cmpl;
        logic acc_err;
        logic prot_viol;
        logic busy;
        logic [`FCSF_CSTAT_W-1:0] cmpl_stat;
        logic launch;
        logic seq_block;
        logic [`FCSF_IRQ_W-1:0] irq_sts;
        logic [`FCSF_IRQ_W-1:0] irq_msk;
        logic irq;
    } fcsf_st_s;
endpackage

//--- fcsf_top.sv
// fcsf_top.sv: flash command status flags behind an AXI4-Lite slave, with interrupt status and mask
// assumes: command engine on the same clock gives one-cycle event pulses and a busy level
`timescale 1ns/1ps
`include "fcsf_map.svh"
module fcsf_top (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_AWVALID,
    input wire fcsf_pkg::fcsf_addr_t I_AWADDR,
    output logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_WREADY,
    output logic O_BVALID,
    output logic [1:0] O_BRESP,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire fcsf_pkg::fcsf_addr_t I_ARADDR,
    output logic O_ARREADY,
    output logic O_RVALID,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    input wire logic I_RREADY,
    input wire logic I_CMD_DONE,
    input wire logic I_SEQ_VIOL,
    input wire logic I_ILLEGAL_CMD,
    input wire logic I_EMU_INIT_ERR,
    input wire logic I_PROT_VIOL,
    input wire logic I_EMU_BUSY,
    input wire logic [1:0] I_CMPL_STAT_SET,
    output logic O_CMD_LAUNCH,
    output logic O_SEQ_BLOCK,
    output logic O_IRQ
);
    import fcsf_pkg::*;

    // reset image of the whole state
    localparam fcsf_st_s ST_RST = '{
        awready: 1'b1,
        wready: 1'b1,
        awaddr: '0,
        wdata: '0,
        wstrb: '0,
        wst: FCSF_WR_IDLE,
        bresp: `FCSF_RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: '0,
        rresp: `FCSF_RESP_OKAY,
        rd_stat: 1'b0,
        cmd_cmpl: `FCSF_CMD_CMPL_RST,
        acc_err: 1'b0,
        prot_viol: 1'b0,
        busy: 1'b0,
        cmpl_stat: '0,
        launch: 1'b0,
        seq_block: 1'b0,
        irq_sts: '0,
        irq_msk: `FCSF_IRQ_MSK_RST,
        irq: 1'b0
    };

    fcsf_st_s q;
    fcsf_st_s d;
    logic wr_fire;
    logic wr_stat;
    logic acc_ev;
    logic launch_ok;
    logic [`FCSF_IRQ_W-1:0] irq_ev;

    // address decode shared by read and write paths
    function automatic logic hit(input fcsf_addr_t a, input fcsf_addr_t ofs);
        hit = (a[`FCSF_ADDR_W-1:2] == ofs[`FCSF_ADDR_W-1:2]);
    endfunction

    function automatic logic [7:0] stat_word(input fcsf_st_s s);
        stat_word = '0;
        stat_word[`FCSF_BIT_CMD_CMPL] = s.cmd_cmpl;
        stat_word[`FCSF_BIT_ACC_ERR] = s.acc_err;
        stat_word[`FCSF_BIT_PROT_VIOL] = s.prot_viol;
        stat_word[`FCSF_BIT_BUSY] = s.busy;
        stat_word[`FCSF_BIT_RSVD] = 1'b0;
        stat_word[`FCSF_BIT_CSTAT_LO +: `FCSF_CSTAT_W] = s.cmpl_stat;
    endfunction

    assign wr_fire = !q.awready && !q.wready && (q.wst == FCSF_WR_IDLE);
    assign wr_stat = wr_fire && hit(q.awaddr, `FCSF_OFS_STAT) && q.wstrb[0];
    assign acc_ev = I_SEQ_VIOL || I_ILLEGAL_CMD || I_EMU_INIT_ERR;
    // launch refused while either violation flag stands
    assign launch_ok = wr_stat && q.wdata[`FCSF_BIT_CMD_CMPL] && q.cmd_cmpl
        && !q.acc_err && !q.prot_viol;

    always_comb begin
        d = q;
        d.launch = 1'b0;
        irq_ev = '0;
        // write address and data, either order
        if (I_AWVALID && q.awready) begin
            d.awaddr = I_AWADDR;
            d.awready = 1'b0;
        end
        if (I_WVALID && q.wready) begin
            d.wdata = I_WDATA;
            d.wstrb = I_WSTRB;
            d.wready = 1'b0;
        end
        if (wr_fire) begin
            d.wst = FCSF_WR_RESP;
            if (hit(q.awaddr, `FCSF_OFS_STAT) || hit(q.awaddr, `FCSF_OFS_IRQ_STS)
                || hit(q.awaddr, `FCSF_OFS_IRQ_MSK)) begin
                d.bresp = `FCSF_RESP_OKAY;
            end else begin
                d.bresp = `FCSF_RESP_DECERR;
            end
        end
        if ((q.wst == FCSF_WR_RESP) && I_BREADY) begin
            d.wst = FCSF_WR_IDLE;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        // read channel
        if (I_ARVALID && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = `FCSF_RESP_OKAY;
            d.rd_stat = 1'b0;
            d.rdata = '0;
            if (hit(I_ARADDR, `FCSF_OFS_STAT)) begin
                d.rdata[7:0] = stat_word(q);
                d.rd_stat = 1'b1;
            end else if (hit(I_ARADDR, `FCSF_OFS_IRQ_STS)) begin
                d.rdata[`FCSF_IRQ_W-1:0] = q.irq_sts;
            end else if (hit(I_ARADDR, `FCSF_OFS_IRQ_MSK)) begin
                d.rdata[`FCSF_IRQ_W-1:0] = q.irq_msk;
            end else begin
                d.rresp = `FCSF_RESP_DECERR;
            end
        end
        if (q.rvalid && I_RREADY) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        // write-one-to-clear, set wins below
        if (wr_stat && q.wdata[`FCSF_BIT_ACC_ERR]) begin
            d.acc_err = 1'b0;
        end
        if (wr_stat && q.wdata[`FCSF_BIT_PROT_VIOL]) begin
            d.prot_viol = 1'b0;
        end
        if (acc_ev) begin
            d.acc_err = 1'b1;
            irq_ev[`FCSF_IRQ_ACC] = 1'b1;
        end
        if (I_PROT_VIOL) begin
            d.prot_viol = 1'b1;
            irq_ev[`FCSF_IRQ_PROT] = 1'b1;
        end
        // command launch and completion
        if (launch_ok) begin
            d.cmd_cmpl = 1'b0;
            d.launch = 1'b1;
            d.cmpl_stat = '0;
        end
        if (!q.cmd_cmpl && (I_CMD_DONE || acc_ev || I_PROT_VIOL)) begin
            d.cmd_cmpl = 1'b1;
            irq_ev[`FCSF_IRQ_CMD] = 1'b1;
        end
        // completion status set only from the engine, never from writes; a launch write clears it
        d.cmpl_stat = d.cmpl_stat | I_CMPL_STAT_SET;
        if (|I_CMPL_STAT_SET) begin
            irq_ev[`FCSF_IRQ_MGS] = 1'b1;
        end
        d.busy = !d.cmd_cmpl || I_EMU_BUSY;
        d.seq_block = d.prot_viol;
        // interrupt status and mask
        if (wr_fire && hit(q.awaddr, `FCSF_OFS_IRQ_STS) && q.wstrb[0]) begin
            d.irq_sts = q.irq_sts & ~q.wdata[`FCSF_IRQ_W-1:0];
        end
        d.irq_sts = d.irq_sts | irq_ev;
        if (wr_fire && hit(q.awaddr, `FCSF_OFS_IRQ_MSK) && q.wstrb[0]) begin
            d.irq_msk = q.wdata[`FCSF_IRQ_W-1:0];
        end
        d.irq = |(d.irq_sts & d.irq_msk);
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign O_AWREADY = q.awready;
    assign O_WREADY = q.wready;
    assign O_BVALID = (q.wst == FCSF_WR_RESP);
    assign O_BRESP = q.bresp;
    assign O_ARREADY = q.arready;
    assign O_RVALID = q.rvalid;
    assign O_RDATA = q.rdata;
    assign O_RRESP = q.rresp;
    assign O_CMD_LAUNCH = q.launch;
    assign O_SEQ_BLOCK = q.seq_block;
    assign O_IRQ = q.irq;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    sequence s_launch_req;
        wr_stat && q.wdata[`FCSF_BIT_CMD_CMPL] && q.cmd_cmpl && !q.acc_err && !q.prot_viol;
    endsequence

    sequence s_launch_seen;
        q.launch && !q.cmd_cmpl ##1 !q.launch;
    endsequence

    sequence s_cmd_running_quiet;
        !q.cmd_cmpl && !I_CMD_DONE && !acc_ev && !I_PROT_VIOL;
    endsequence

    sequence s_cmd_viol;
        !q.cmd_cmpl && (acc_ev || I_PROT_VIOL);
    endsequence

    chk_launch_clears_command_complete_flag: assert property (s_launch_req |=> s_launch_seen)
        else $error("launch did not clear command complete");
    chk_command_complete_flag_done_sets: assert property (!q.cmd_cmpl && I_CMD_DONE |=> q.cmd_cmpl && q.irq_sts[`FCSF_IRQ_CMD])
        else $error("command done did not set command complete");
    chk_command_complete_flag_stays_low: assert property (s_cmd_running_quiet |=> !q.cmd_cmpl)
        else $error("command complete rose without an ending event");
    chk_command_complete_flag_viol_ends: assert property (s_cmd_viol |=> q.cmd_cmpl)
        else $error("violation did not end the command");
    chk_launch_one_pulse: assert property (q.launch |=> !q.launch)
        else $error("launch pulse longer than one cycle");
    chk_access_error_flag_blocks_launch: assert property (wr_stat && q.acc_err |=> !q.launch)
        else $error("launch taken with access error set");
    chk_access_error_flag_event_sets: assert property (acc_ev |=> q.acc_err)
        else $error("access error event lost");
    chk_access_error_flag_zero_write: assert property (
        wr_stat && !q.wdata[`FCSF_BIT_ACC_ERR] && q.acc_err |=> q.acc_err)
        else $error("access error cleared by a zero write");
    chk_access_error_flag_one_clears: assert property (
        wr_stat && q.wdata[`FCSF_BIT_ACC_ERR] && !acc_ev |=> !q.acc_err)
        else $error("access error not cleared by a one write");
    chk_protection_violation_flag_event_sets: assert property (I_PROT_VIOL |=> q.prot_viol ##0 O_SEQ_BLOCK)
        else $error("protection violation not flagged");
    chk_protection_violation_flag_zero_write: assert property (
        wr_stat && !q.wdata[`FCSF_BIT_PROT_VIOL] && q.prot_viol |=> q.prot_viol)
        else $error("protection violation cleared by a zero write");
    chk_protection_violation_flag_one_clears: assert property (
        wr_stat && q.wdata[`FCSF_BIT_PROT_VIOL] && !I_PROT_VIOL |=> !q.prot_viol)
        else $error("protection violation not cleared by a one write");
    chk_protection_violation_flag_blocks_launch: assert property (q.prot_viol && wr_stat |=> !q.launch)
        else $error("launch taken with protection violation set");
    chk_seq_block_level: assert property (q.prot_viol |-> O_SEQ_BLOCK)
        else $error("sequence block low with protection violation set");
    chk_busy_while_running: assert property (!q.cmd_cmpl |-> q.busy)
        else $error("busy low while a command runs");
    chk_busy_follows: assert property (1'b1 |=> q.busy == (!q.cmd_cmpl || $past(I_EMU_BUSY)))
        else $error("busy does not follow command or emulated eeprom work");
    chk_rsvd_reads_zero: assert property (q.rvalid && q.rd_stat |-> !q.rdata[`FCSF_BIT_RSVD])
        else $error("reserved status bit read as one");
    chk_mgstat_sets: assert property (
        |I_CMPL_STAT_SET |=> (q.cmpl_stat & $past(I_CMPL_STAT_SET)) == $past(I_CMPL_STAT_SET))
        else $error("completion status not set");
    chk_mgstat_readonly: assert property (
        wr_stat && !launch_ok && !(|I_CMPL_STAT_SET) |=> q.cmpl_stat == $past(q.cmpl_stat))
        else $error("completion status changed by a write");
endmodule // fcsf_top

//--- tb_top.sv
// tb_top.sv: self-checking bench of the flash status flags with a flag model
// assumes: fcsf_top on one 250 MHz clock, AXI4-Lite driven here, event pulses from the bench
`timescale 1ns/1ps
module tb_top;
    import fcsf_pkg::*;
    logic clk, rst, awv, wv, bre, arv, rre, eb;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0] ws, is, ms;
    logic [4:0] evb;
    logic [1:0] mgv, br, rr, rp;
    logic awr, wr_q, bv, arr, rv, lau, sblk, irq, cc, ae, pv;
    logic [1:0] mg;
    logic [31:0] nl, n_launch, r;
    int n_fail, comparisons, k;
    fcsf_top dut (.I_CORE_CLK(clk), .I_RST(rst), .I_AWVALID(awv), .I_AWADDR(awa), .O_AWREADY(awr),
        .I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(ws), .O_WREADY(wr_q), .O_BVALID(bv), .O_BRESP(br),
        .I_BREADY(bre), .I_ARVALID(arv), .I_ARADDR(ara), .O_ARREADY(arr), .O_RVALID(rv),
        .O_RDATA(rdat), .O_RRESP(rr), .I_RREADY(rre), .I_CMD_DONE(evb[0]), .I_SEQ_VIOL(evb[1]),
        .I_ILLEGAL_CMD(evb[2]), .I_EMU_INIT_ERR(evb[3]), .I_PROT_VIOL(evb[4]), .I_EMU_BUSY(eb),
        .I_CMPL_STAT_SET(mgv), .O_CMD_LAUNCH(lau), .O_SEQ_BLOCK(sblk), .O_IRQ(irq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (lau === 1'b1) n_launch <= n_launch + 32'h1;
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_q === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 50);
        tmo(n);
        chk("bresp", br, 32'h0);
        bre <= 1'b0;
        @(posedge clk);
        if (s[0]) case (a)
            8'h00: begin
                if (d[7] && cc && !ae && !pv) begin
                    cc = 1'b0;
                    mg = 2'h0;
                    nl++;
                end
                if (d[5]) ae = 1'b0;
                if (d[4]) pv = 1'b0;
            end
            8'h04: is = is & ~d[3:0];
            8'h08: ms = d[3:0];
            default: ;
        endcase
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] p);
        int n;
        n = 0;
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 50);
        tmo(n);
        d = rdat;
        p = rr;
        rre <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ev(input int e, input logic [1:0] v);
        if (e < 5) evb <= 5'h1 << e;
        else mgv <= v;
        @(posedge clk);
        evb <= 5'h0; mgv <= 2'h0;
        @(posedge clk);
        if (e inside {[1:3]}) begin ae = 1'b1; is[1] = 1'b1; end
        if (e == 4) begin pv = 1'b1; is[2] = 1'b1; end
        if (e == 5) begin mg = mg | v; if (v != 2'h0) is[3] = 1'b1; end
        if (e < 5 && !cc) begin cc = 1'b1; is[0] = 1'b1; end
    endtask
    task automatic cmp_all(input string t);
        logic [1:0] p;
        rd(8'h00, r, p);
        chk("rresp", p, 32'h0);
        chk("status", r, {24'h0, cc, 1'b0, ae, pv, !cc | eb, 1'b0, mg});
        rd(8'h04, r, p);
        chk("irq_sts", r, {28'h0, is});
        rd(8'h08, r, p);
        chk("irq_msk", r, {28'h0, ms});
        chk("irq", irq, |(is & ms));
        chk("seq_block", sblk, pv);
        chk("launches", n_launch, nl);
        $display("test %s done", t);
    endtask
    initial begin
        rst = 1'b1; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0; rre = 1'b0; eb = 1'b0;
        awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'hF; evb = 5'h0; mgv = 2'h0;
        cc = 1'b1; ae = 1'b0; pv = 1'b0; mg = 2'h0; is = 4'h0; ms = 4'h0; nl = 32'h0; n_launch = 32'h0;
        k = $urandom(32'h70D1);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp_all("reset");
        rd(8'h0C, r, rp);
        chk("unmapped rdata", r, 32'h0);
        chk("unmapped rresp", rp, 32'h3);
        wr(8'h08, $urandom & 32'hF, 4'hF);
        cmp_all("mask");
        wr(8'h08, 32'hF, 4'hF);
        wr(8'h00, 32'h80, 4'hE);
        cmp_all("strobe");
        wr(8'h00, 32'h80, 4'hF);
        cmp_all("launch");
        ev(0, 2'h0);
        cmp_all("done");
        wr(8'h00, 32'h80, 4'hF);
        ev(4, 2'h0);
        wr(8'h00, 32'h80, 4'hF);
        wr(8'h00, 32'h00, 4'hF);
        cmp_all("protect");
        wr(8'h00, 32'h90, 4'hF);
        cmp_all("protect clear");
        for (k = 1; k < 4; k++) begin
            ev(k, 2'h0);
            wr(8'h00, 32'h80, 4'hF);
            cmp_all("access error");
            wr(8'h00, 32'hA0, 4'hF);
            cmp_all("access clear");
        end
        ev(5, 2'($urandom_range(3, 1)));
        eb <= 1'b1;
        wr(8'h00, 32'h0F, 4'hF);
        cmp_all("read only");
        eb <= 1'b0;
        wr(8'h00, 32'h80, 4'hF);
        wr(8'h04, 32'hF, 4'hF);
        cmp_all("irq clear");
        stop_test();
    end
endmodule // tb_top
